// file: common/shsp_pkg.sv
// Constants and types of the sensor host serial port
package shsp_pkg;
  localparam logic [6:0] REG_MOTION = 7'h02;
  localparam logic [6:0] REG_DELTA_X = 7'h03;
  localparam logic [6:0] REG_DELTA_Y = 7'h04;
  localparam logic [6:0] REG_SURF_Q = 7'h05;
  localparam logic [6:0] REG_EXP_HI = 7'h06;
  localparam logic [6:0] REG_EXP_LO = 7'h07;
  localparam logic [6:0] REG_PEAK = 7'h08;
  localparam logic [6:0] REG_IFACE_CFG = 7'h1C;
  localparam logic [7:0] IFACE_CFG_RST = 8'h00;
  localparam logic [7:0] IFACE_CFG_BURST = 8'h10;
  localparam int BURST_BYTES = 7;
  localparam int BURST_BITS = 8 * BURST_BYTES;
  localparam int BURST_MIN_BYTES = 3;
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [6:0] SLAVE_ID_00 = 7'h33;
  localparam logic [6:0] SLAVE_ID_01 = 7'h3B;
  localparam logic [6:0] SLAVE_ID_10 = 7'h53;
  localparam logic [6:0] SLAVE_ID_11 = 7'h57;
  localparam int SYNC_W = 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h1B;
  localparam int SY_CS = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_SCL = 3;
  localparam int SY_SDA = 4;
  localparam int SY_A0 = 5;
  localparam int SY_A1 = 6;
  localparam int SY_TWI = 7;
  typedef enum logic [1:0] {SP_ADDR, SP_WDATA, SP_RDATA, SP_LOCK} shsp_spi_st_t;
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_REG, T_WDATA, T_DACK, T_RDATA, T_HACK} shsp_twi_st_t;
endpackage

// file: common/shsp_mem_if.sv
// Register store port between the serial engines and the register memory
`timescale 1ns/1ps
`default_nettype none
interface shsp_mem_if;
  logic we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: design/shsp_regmem.sv
// Register memory: 128 bytes, registered read data
`timescale 1ns/1ps
`default_nettype none
module shsp_regmem (
  input wire logic clk,
  shsp_mem_if.store mem
);
  logic [7:0] cells_q [0:127];
  logic [7:0] rdata_q;

  // Read data lags the address by one clock
  always_ff @(posedge clk) begin
    if (mem.we) begin
      cells_q[mem.addr] <= mem.wdata;
    end
    rdata_q <= cells_q[mem.addr];
  end

  assign mem.rdata = rdata_q;
endmodule // shsp_regmem
`default_nettype wire

// file: design/shsp_port.sv
// Sensor host serial port: SPI burst read and two-wire slave
//
// How it works
// - Writing 0x10 to register 0x1c makes a motion read a burst.
// - Burst order: flags, Y, X, quality, exposure high, low, peak.
// - Chip select high after three or more bytes ends burst cleanly.
// - Burst bytes follow back to back at normal clock rate.
// - Burst set is captured at the last address bit.
// - After a burst all commands are ignored until chip select rises.
// - Chip select high aborts any SPI transaction and resets the SPI state, bit count and burst flag.
// - Select pins pick slave id 0x33, 0x3b, 0x53 or 0x57.
// - Data line driven only for acknowledge or read data.
// - START and STOP are detected while the clock is high.
// - Packets are eight bits, MSB first, then one acknowledge.
// - Receiver drives acknowledge: low acknowledges, high refuses.
// - First packet: 7-bit slave id then direction, 1 means read.
// - Register packet: step flag in MSB, then 7-bit index.
// - With step flag set each byte goes to the next register.
// - On id match every host byte is acknowledged low.
// - Read: device acknowledges, sends bytes; host ack continues, refusal ends.
`timescale 1ns/1ps
`default_nettype none
module shsp_port (
  input wire logic clk,
  input wire logic srst,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_0,
  input wire logic addr_select_1,
  input wire logic twi_select,
  input wire logic [7:0] motion_flags,
  input wire logic [7:0] delta_y,
  input wire logic [7:0] delta_x,
  input wire logic [7:0] surface_quality,
  input wire logic [7:0] exposure_hi,
  input wire logic [7:0] exposure_lo,
  input wire logic [7:0] peak_pixel
);
  import shsp_pkg::*;

  shsp_mem_if mem ();
  shsp_regmem u_mem (.clk(clk), .mem(mem));

  logic [SYNC_W-1:0] s1_q, s2_q, s3_q;
  logic [BURST_BITS-1:0] live_set;
  logic [7:0] io_mode_q, io_mode_d;
  logic miso_oe_q, miso_oe_d;
  logic cs_hi, twi_mode, spi_on, sclk_rise, sclk_fall;
  logic scl_rise, scl_fall, twi_start, twi_stop;
  logic [6:0] my_id;
  logic [7:0] spi_byte, twi_byte;

  // Live motion values in burst order; stale copies in memory are never shown
  assign live_set = {motion_flags, delta_y, delta_x, surface_quality,
                     exposure_hi, exposure_lo, peak_pixel};

  function automatic logic [7:0] fetch(input logic [6:0] a, input logic [7:0] stored,
                                       input logic [7:0] cfg,
                                       input logic [BURST_BITS-1:0] live);
    logic [7:0] f;
    f = stored;
    unique case (a)
      REG_MOTION: f = live[55:48];
      REG_DELTA_Y: f = live[47:40];
      REG_DELTA_X: f = live[39:32];
      REG_SURF_Q: f = live[31:24];
      REG_EXP_HI: f = live[23:16];
      REG_EXP_LO: f = live[15:8];
      REG_PEAK: f = live[7:0];
      REG_IFACE_CFG: f = cfg;
      default: f = stored;
    endcase
    return f;
  endfunction

  // Pins are asynchronous: two flops, third flop only for edge finding
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= {twi_select, addr_select_1, addr_select_0, sda_in, scl, mosi, sclk,
               chip_select_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign cs_hi = s2_q[SY_CS];
  assign twi_mode = s2_q[SY_TWI];
  assign spi_on = !twi_mode && !cs_hi;
  assign sclk_rise = s2_q[SY_SCLK] && !s3_q[SY_SCLK];
  assign sclk_fall = !s2_q[SY_SCLK] && s3_q[SY_SCLK];
  assign scl_rise = s2_q[SY_SCL] && !s3_q[SY_SCL];
  assign scl_fall = !s2_q[SY_SCL] && s3_q[SY_SCL];
  assign twi_start = s2_q[SY_SCL] && s3_q[SY_SCL] && s3_q[SY_SDA] && !s2_q[SY_SDA];
  assign twi_stop = s2_q[SY_SCL] && s3_q[SY_SCL] && !s3_q[SY_SDA] && s2_q[SY_SDA];
  assign my_id = s2_q[SY_A0] ? (s2_q[SY_A1] ? SLAVE_ID_11 : SLAVE_ID_10) :
                 (s2_q[SY_A1] ? SLAVE_ID_01 : SLAVE_ID_00);

  // SPI engine
  shsp_spi_st_t spi_st_q, spi_st_d;
  logic [5:0] spi_cnt_q, spi_cnt_d;
  logic [7:0] spi_rx_q, spi_rx_d, spi_wdata;
  logic [6:0] spi_addr_q, spi_addr_d;
  logic [BURST_BITS-1:0] buf_q, buf_d;
  logic [1:0] pend_q, pend_d;
  logic miso_q, miso_d, burst_q, burst_d, spi_we;

  assign spi_byte = fetch(spi_addr_q, mem.rdata, io_mode_q, live_set);

  always_comb begin
    spi_st_d = spi_st_q;
    spi_cnt_d = spi_cnt_q;
    spi_rx_d = spi_rx_q;
    spi_addr_d = spi_addr_q;
    buf_d = buf_q;
    pend_d = {pend_q[0], 1'b0};
    miso_d = miso_q;
    burst_d = burst_q;
    spi_we = 1'b0;
    spi_wdata = {spi_rx_q[6:0], s2_q[SY_MOSI]};
    // Memory read data is valid two clocks after the address is set
    if (pend_q[1]) begin
      buf_d = {spi_byte, {(BURST_BITS - 8){1'b0}}};
    end
    if (!spi_on) begin
      spi_st_d = SP_ADDR;
      spi_cnt_d = 6'h00;
      burst_d = 1'b0;
    end else if (sclk_rise) begin
      spi_rx_d = spi_wdata;
      spi_cnt_d = spi_cnt_q + 6'h01;
      unique case (spi_st_q)
        SP_ADDR: begin
          if (spi_cnt_q == 6'h07) begin
            spi_cnt_d = 6'h00;
            spi_addr_d = spi_wdata[6:0];
            if (spi_wdata[CMD_WRITE_BIT]) begin
              spi_st_d = SP_WDATA;
            end else begin
              spi_st_d = SP_RDATA;
              if (io_mode_q == IFACE_CFG_BURST && spi_wdata[6:0] == REG_MOTION) begin
                burst_d = 1'b1;
                buf_d = live_set;
              end else begin
                pend_d = 2'h1;
              end
            end
          end
        end
        SP_WDATA: begin
          if (spi_cnt_q == 6'h07) begin
            spi_we = 1'b1;
            spi_st_d = SP_ADDR;
            spi_cnt_d = 6'h00;
          end
        end
        SP_RDATA: begin
          if (burst_q && spi_cnt_q == 6'(BURST_BITS - 1)) begin
            spi_st_d = SP_LOCK;
          end else if (!burst_q && spi_cnt_q == 6'h07) begin
            spi_st_d = SP_ADDR;
            spi_cnt_d = 6'h00;
          end
        end
        SP_LOCK: begin
          spi_cnt_d = spi_cnt_q;
        end
      endcase
    end else if (sclk_fall && spi_st_q == SP_RDATA) begin
      // No gap between bytes: the buffer simply keeps shifting
      miso_d = buf_q[BURST_BITS-1];
      buf_d = {buf_q[BURST_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      spi_st_q <= SP_ADDR;
      spi_cnt_q <= 6'h00;
      spi_rx_q <= 8'h00;
      spi_addr_q <= 7'h00;
      buf_q <= '0;
      pend_q <= 2'h0;
      miso_q <= 1'b0;
      burst_q <= 1'b0;
    end else begin
      spi_st_q <= spi_st_d;
      spi_cnt_q <= spi_cnt_d;
      spi_rx_q <= spi_rx_d;
      spi_addr_q <= spi_addr_d;
      buf_q <= buf_d;
      pend_q <= pend_d;
      miso_q <= miso_d;
      burst_q <= burst_d;
    end
  end

  // Two-wire slave engine
  shsp_twi_st_t twi_st_q, twi_st_d, nxt_q, nxt_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic [7:0] sh_q, sh_d;
  logic [6:0] ptr_q, ptr_d;
  logic ai_q, ai_d, oe_q, oe_d, hack_q, hack_d, twi_we, tload;

  assign twi_byte = fetch(ptr_q, mem.rdata, io_mode_q, live_set);

  always_comb begin
    twi_st_d = twi_st_q;
    nxt_d = nxt_q;
    tcnt_d = tcnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ai_d = ai_q;
    oe_d = oe_q;
    hack_d = hack_q;
    twi_we = 1'b0;
    tload = 1'b0;
    if (!twi_mode || twi_stop) begin
      twi_st_d = T_IDLE;
      oe_d = 1'b0;
    end else if (twi_start) begin
      twi_st_d = T_ADDR;
      tcnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      unique case (twi_st_q)
        T_ADDR, T_REG, T_WDATA: begin
          sh_d = {sh_q[6:0], s2_q[SY_SDA]};
          tcnt_d = tcnt_q + 4'h1;
        end
        T_RDATA: tcnt_d = tcnt_q + 4'h1;
        T_HACK: hack_d = !s2_q[SY_SDA];
        T_IDLE, T_DACK: hack_d = hack_q;
      endcase
    end else if (scl_fall) begin
      unique case (twi_st_q)
        T_ADDR: begin
          if (tcnt_q == 4'h8) begin
            if (sh_q[7:1] == my_id) begin
              twi_st_d = T_DACK;
              nxt_d = sh_q[0] ? T_RDATA : T_REG;
              oe_d = 1'b1;
            end else begin
              twi_st_d = T_IDLE;
            end
          end
        end
        T_REG: begin
          if (tcnt_q == 4'h8) begin
            ptr_d = sh_q[6:0];
            ai_d = sh_q[7];
            twi_st_d = T_DACK;
            nxt_d = T_WDATA;
            oe_d = 1'b1;
          end
        end
        T_WDATA: begin
          if (tcnt_q == 4'h8) begin
            twi_we = 1'b1;
            ptr_d = ptr_q + {6'h00, ai_q};
            twi_st_d = T_DACK;
            oe_d = 1'b1;
          end
        end
        T_DACK: begin
          tcnt_d = 4'h0;
          twi_st_d = nxt_q;
          oe_d = 1'b0;
          tload = (nxt_q == T_RDATA);
        end
        T_RDATA: begin
          if (tcnt_q == 4'h8) begin
            oe_d = 1'b0;
            twi_st_d = T_HACK;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = !sh_q[6];
          end
        end
        T_HACK: begin
          tcnt_d = 4'h0;
          twi_st_d = hack_q ? T_RDATA : T_IDLE;
          tload = hack_q;
        end
        T_IDLE: oe_d = 1'b0;
      endcase
      if (tload) begin
        sh_d = twi_byte;
        oe_d = !twi_byte[7];
        ptr_d = ptr_q + {6'h00, ai_q};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      twi_st_q <= T_IDLE;
      nxt_q <= T_IDLE;
      tcnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 7'h00;
      ai_q <= 1'b0;
      oe_q <= 1'b0;
      hack_q <= 1'b0;
    end else begin
      twi_st_q <= twi_st_d;
      nxt_q <= nxt_d;
      tcnt_q <= tcnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ai_q <= ai_d;
      oe_q <= oe_d;
      hack_q <= hack_d;
    end
  end

  // Memory port belongs to whichever link is selected
  assign mem.we = twi_mode ? twi_we : spi_we;
  assign mem.addr = twi_mode ? ptr_q : spi_addr_q;
  assign mem.wdata = twi_mode ? sh_q : spi_wdata;

  always_comb begin
    io_mode_d = io_mode_q;
    if (mem.we && mem.addr == REG_IFACE_CFG) begin
      io_mode_d = mem.wdata;
    end
    miso_oe_d = spi_on;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      io_mode_q <= IFACE_CFG_RST;
      miso_oe_q <= 1'b0;
    end else begin
      io_mode_q <= io_mode_d;
      miso_oe_q <= miso_oe_d;
    end
  end

  assign miso = miso_q;
  assign miso_oe = miso_oe_q;
  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_burst_enable: assert property ($rose(burst_q) |->
    $past(io_mode_q) == IFACE_CFG_BURST && spi_addr_q == REG_MOTION)
    else $error("burst started without enable");
  a_burst_capture: assert property ($rose(burst_q) |-> buf_q == $past(live_set))
    else $error("burst set not captured in order");
  a_miso_shift: assert property (spi_on && sclk_fall && spi_st_q == SP_RDATA
    |=> miso_q == $past(buf_q[BURST_BITS-1]) && miso_oe)
    else $error("read bit not shifted out");
  a_cs_abort: assert property (!spi_on |=>
    spi_st_q == SP_ADDR && !burst_q && spi_cnt_q == 6'h00)
    else $error("chip select did not reset port");
  a_lock_hold: assert property (spi_st_q == SP_LOCK && spi_on |=>
    spi_st_q == SP_LOCK && burst_q && $stable(miso_q))
    else $error("command taken after burst");
  a_sda_drive: assert property (sda_oe |-> twi_st_q inside {T_DACK, T_RDATA})
    else $error("data line driven outside ack or read");
  a_start_seen: assert property (twi_mode && twi_start |=>
    twi_st_q == T_ADDR && !sda_oe && tcnt_q == 4'h0)
    else $error("start not taken");
  a_stop_seen: assert property (twi_stop |=> twi_st_q == T_IDLE && !sda_oe)
    else $error("stop not taken");
  a_id_ack: assert property (twi_mode && scl_fall && twi_st_q == T_ADDR &&
    tcnt_q == 4'h8 && sh_q[7:1] == my_id |=> twi_st_q == T_DACK && sda_oe)
    else $error("own id not acknowledged");
  a_id_ignore: assert property (twi_mode && scl_fall && twi_st_q == T_ADDR &&
    tcnt_q == 4'h8 && sh_q[7:1] != my_id |=> twi_st_q == T_IDLE && !sda_oe)
    else $error("foreign id answered");
  a_ptr_load: assert property (twi_mode && scl_fall && twi_st_q == T_REG &&
    tcnt_q == 4'h8 |=> ptr_q == $past(sh_q[6:0]) && ai_q == $past(sh_q[7]))
    else $error("register packet misread");
  a_ptr_step: assert property (twi_mode && scl_fall && twi_st_q == T_WDATA &&
    tcnt_q == 4'h8 |=> ptr_q == 7'($past(ptr_q) + {6'h00, $past(ai_q)}) ##1 sda_oe)
    else $error("pointer step wrong");
  a_host_ack: assert property (twi_mode && scl_fall && twi_st_q == T_HACK
    |=> twi_st_q == ($past(hack_q) ? T_RDATA : T_IDLE))
    else $error("host acknowledge misread");

  c_burst_full: cover property (burst_q && spi_st_q == SP_RDATA ##1 spi_st_q == SP_LOCK);
  c_burst_early: cover property (burst_q && spi_cnt_q == 6'(8 * BURST_MIN_BYTES) ##1 !burst_q);
  c_twi_read: cover property (twi_st_q == T_HACK ##1 twi_st_q == T_RDATA);
  c_twi_write: cover property (twi_mode && mem.we && ai_q);
endmodule // shsp_port
`default_nettype wire

// file: test/shsp_host.sv
// Host-side master model driving the SPI and two-wire links
`timescale 1ns/1ps
`default_nettype none
module shsp_host (
  output logic chip_select_n,
  output logic sclk,
  output logic mosi,
  output logic scl,
  output logic sda_pull,
  input wire logic miso,
  input wire logic sda
);
  localparam int H = 24;
  // Two-wire quarter bit is kept wide so the synced acknowledge settles before SCL rises
  localparam int Q = 24;
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Clock idles high between frames; MISO taken on the rising edge
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #H sclk = 1'b0;
      mosi = tx[i];
      #H sclk = 1'b1;
      rx[i] = miso;
    end
  endtask
  task automatic spi_read(input logic [6:0] a, input int n, input logic junk,
                          output logic [55:0] d);
    logic [7:0] b;
    d = '0;
    chip_select_n = 1'b0;
    spi_byte({1'b0, a}, b);
    #4000;
    for (int k = 0; k < n; k++) begin
      spi_byte(8'hFF, b);
      d = {d[47:0], b};
    end
    if (junk) begin
      spi_byte(8'h9C, b);
      spi_byte(8'h00, b);
    end
    #H chip_select_n = 1'b1;
    #500;
  endtask
  task automatic spi_write(input logic [7:0] a, input logic [7:0] v, input logic cut);
    logic [7:0] b;
    chip_select_n = 1'b0;
    spi_byte(a, b);
    if (!cut) spi_byte(v, b);
    #H chip_select_n = 1'b1;
    #500;
  endtask
  task automatic t_bit(input logic tx, output logic rx);
    #Q sda_pull = ~tx;
    #Q scl = 1'b1;
    #Q rx = sda;
    #Q scl = 1'b0;
  endtask
  task automatic t_start();
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic t_stop();
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  task automatic t_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
    for (int i = 7; i >= 0; i--) t_bit(tx[i], rx[i]);
    t_bit(ack_in, ack);
  endtask
endmodule // shsp_host
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the sensor host serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb_top;
  import shsp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic twi_select = 1'b0;
  logic [1:0] sel = 2'b00;
  logic [7:0] live [7] = '{8'h81, 8'h7E, 8'h05, 8'h40, 8'h12, 8'h34, 8'hC9};
  logic [6:0] ids [4] = '{SLAVE_ID_00, SLAVE_ID_01, SLAVE_ID_10, SLAVE_ID_11};
  logic miso, miso_oe, sda_out, sda_oe, cs_n, sclk, mosi, scl, sda_pull;
  wire logic sda_w;
  wire logic miso_w;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] r0, r1;
  logic a;
  // Open-drain wire with pull-up
  assign sda_w = ~(sda_pull | (sda_oe & ~sda_out));
  // A released MISO shows the inverse so a stale bit never passes
  assign miso_w = miso_oe ? miso : ~miso;
  always #2.5 clk = ~clk;
  shsp_port shsp_port_i (.clk(clk), .srst(srst), .chip_select_n(cs_n), .sclk(sclk),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_0(sel[1]), .addr_select_1(sel[0]),
    .twi_select(twi_select), .motion_flags(live[0]), .delta_y(live[1]), .delta_x(live[2]),
    .surface_quality(live[3]), .exposure_hi(live[4]), .exposure_lo(live[5]),
    .peak_pixel(live[6]));
  shsp_host shsp_host_i (.chip_select_n(cs_n), .sclk(sclk), .mosi(mosi), .scl(scl),
    .sda_pull(sda_pull), .miso(miso_w), .sda(sda_w));
  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [55:0] pack_live();
    logic [55:0] e;
    e = '0;
    for (int k = 0; k < 7; k++) e = {e[47:0], live[k]};
    return e;
  endfunction
  task automatic spi_rd(input logic [6:0] ra, input int n, input logic junk,
                        input logic [55:0] exp);
    logic [55:0] d;
    shsp_host_i.spi_read(ra, n, junk, d);
    `CHK(d, exp)
  endtask
  task automatic t_wr(input logic [6:0] id, input logic [7:0] p, input logic [7:0] v0,
                      input logic [7:0] v1, input logic ok);
    logic [2:0] k;
    shsp_host_i.t_start();
    shsp_host_i.t_byte({id, 1'b0}, 1'b1, r0, a);
    `CHK(a, ~ok)
    if (ok) begin
      shsp_host_i.t_byte(p, 1'b1, r0, k[0]);
      shsp_host_i.t_byte(v0, 1'b1, r0, k[1]);
      shsp_host_i.t_byte(v1, 1'b1, r0, k[2]);
      `CHK(k, 3'b000)
    end
    shsp_host_i.t_stop();
  endtask
  task automatic t_rd(input logic [6:0] id, input logic [7:0] p, input logic [7:0] e0,
                      input logic [7:0] e1);
    logic [2:0] k;
    shsp_host_i.t_start();
    shsp_host_i.t_byte({id, 1'b0}, 1'b1, r0, k[0]);
    shsp_host_i.t_byte(p, 1'b1, r0, k[1]);
    shsp_host_i.t_start();
    shsp_host_i.t_byte({id, 1'b1}, 1'b1, r0, k[2]);
    shsp_host_i.t_byte(8'hFF, 1'b0, r0, a);
    shsp_host_i.t_byte(8'hFF, 1'b1, r1, a);
    shsp_host_i.t_stop();
    `CHK({k, r0, r1}, {3'b000, e0, e1})
  endtask
  initial begin
    #200000;
    mismatches++;
    $display("[ERR] %0t run did not finish", $time);
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk);
    `CHK({miso_oe, sda_oe}, 2'b00)
    spi_rd(REG_IFACE_CFG, 1, 1'b0, {48'h0, IFACE_CFG_RST});
    $display("reset test done");
    shsp_host_i.spi_write({1'b1, REG_IFACE_CFG}, IFACE_CFG_BURST, 1'b0);
    spi_rd(REG_IFACE_CFG, 1, 1'b0, {48'h0, IFACE_CFG_BURST});
    fork
      spi_rd(REG_MOTION, 7, 1'b1, pack_live());
      begin
        // Live values move after the address, so only the captured set may appear
        repeat (500) @(posedge clk);
        #1 for (int k = 0; k < 7; k++) live[k] = ~live[k];
      end
    join
    spi_rd(REG_IFACE_CFG, 1, 1'b0, {48'h0, IFACE_CFG_BURST});
    $display("burst test done");
    spi_rd(REG_MOTION, 3, 1'b0, pack_live() >> 32);
    spi_rd(REG_MOTION, 7, 1'b0, pack_live());
    shsp_host_i.spi_write({1'b1, REG_IFACE_CFG}, 8'h00, 1'b1);
    spi_rd(REG_IFACE_CFG, 1, 1'b0, {48'h0, IFACE_CFG_BURST});
    $display("abort test done");
    twi_select = 1'b1;
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      t_wr(ids[s], 8'h9B, {6'h28, sel}, IFACE_CFG_BURST, 1'b1);
      t_rd(ids[s], 8'h9B, {6'h28, sel}, IFACE_CFG_BURST);
      t_wr(ids[3 - s], 8'h9B, 8'h00, 8'h00, 1'b0);
    end
    t_rd(SLAVE_ID_11, {1'b1, REG_MOTION}, live[0], live[2]);
    t_rd(SLAVE_ID_11, {1'b0, REG_MOTION}, live[0], live[0]);
    $display("two-wire test done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
